// ---- rtl/eag_effective_address.v ----
`timescale 1ns/1ps
`default_nettype none
`include "eag_defines.vh"
module eag_effective_address #(
  parameter LEVELS = 16,
  parameter [`EAG_OPC_W-1:0] OPC_JCOND = 5'h1A,
  parameter [`EAG_OPC_W-1:0] OPC_BYTE = 5'h1B,
  parameter [`EAG_OPC_W-1:0] OPC_RBLK = 5'h1C
) (
  input wire clk,
  input wire srst,
  input wire start,
  input wire [`EAG_WORD_W-1:0] instr_word,
  input wire [`EAG_WORD_W-1:0] instr_addr,
  input wire [`EAG_LEVEL_W-1:0] active_level,
  input wire lvl_wr,
  input wire [`EAG_LEVEL_W-1:0] lvl_wr_level,
  input wire [`EAG_WORD_W-1:0] lvl_wr_pointer,
  input wire [`EAG_WORD_W-1:0] lvl_wr_post,
  output wire busy,
  output reg mem_rd,
  output reg [`EAG_WORD_W-1:0] mem_addr,
  input wire mem_ack,
  input wire [`EAG_WORD_W-1:0] mem_rdata,
  output reg ea_valid,
  output reg [`EAG_WORD_W-1:0] ea,
  output reg [`EAG_OPC_W-1:0] ea_opcode,
  output reg ea_bypass
);
  // ----------------------------------------
  // Per-level pointer and post-offset registers
  // ----------------------------------------
  reg [`EAG_WORD_W-1:0] ptr_mem [0:LEVELS-1];
  reg [`EAG_WORD_W-1:0] post_mem [0:LEVELS-1];
  integer i;
  always @(posedge clk)
  begin
    if (srst)
    begin
      for (i = 0; i < LEVELS; i = i + 1)
      begin
        ptr_mem[i] <= `EAG_ADDR_RST;
        post_mem[i] <= `EAG_ADDR_RST;
      end
    end
    else if (lvl_wr)
    begin
      ptr_mem[lvl_wr_level] <= lvl_wr_pointer;
      post_mem[lvl_wr_level] <= lvl_wr_post;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function [`EAG_WORD_W-1:0] sext_disp;
    input [`EAG_WORD_W-1:0] w;
    begin
      sext_disp = {{8{w[`EAG_DISP_MSB]}}, w[`EAG_DISP_MSB:0]};
    end
  endfunction

  // ----------------------------------------
  // Address mode select
  // ----------------------------------------
  localparam [2:0] MODE_REL = 3'h0;
  localparam [2:0] MODE_PTR = 3'h1;
  localparam [2:0] MODE_IND = 3'h2;
  localparam [2:0] MODE_PTR_IND = 3'h3;
  localparam [2:0] MODE_POST = 3'h4;
  localparam [2:0] MODE_PTR_POST = 3'h5;
  localparam [2:0] MODE_IND_POST = 3'h6;
  localparam [2:0] MODE_PTR_IND_POST = 3'h7;

  // Plain post-offset form has no base, the register alone carries it
  function [`EAG_WORD_W-1:0] mode_base;
    input [2:0] mode_bits;
    input [`EAG_WORD_W-1:0] counter;
    input [`EAG_WORD_W-1:0] pointer;
    begin
      case (mode_bits)
        MODE_REL: mode_base = counter;
        MODE_PTR: mode_base = pointer;
        MODE_IND: mode_base = counter;
        MODE_PTR_IND: mode_base = pointer;
        MODE_POST: mode_base = `EAG_ADDR_RST;
        MODE_PTR_POST: mode_base = pointer;
        MODE_IND_POST: mode_base = counter;
        MODE_PTR_IND_POST: mode_base = pointer;
        default: mode_base = counter;
      endcase
    end
  endfunction

  wire [`EAG_OPC_W-1:0] opc = instr_word[`EAG_OPC_MSB:`EAG_OPC_LSB];
  wire f_post = instr_word[`EAG_POST_BIT];
  wire f_deref = instr_word[`EAG_DEREF_BIT];
  wire f_pre = instr_word[`EAG_PRE_BIT];
  wire [`EAG_WORD_W-1:0] disp = sext_disp(instr_word);
  wire own_format = (opc == OPC_JCOND) || (opc == OPC_BYTE) || (opc == OPC_RBLK);
  wire [`EAG_WORD_W-1:0] cur_ptr = ptr_mem[active_level];
  wire [`EAG_WORD_W-1:0] cur_post = post_mem[active_level];

  // Without the pre bit the base is this instruction's address, not the advanced counter (zero for plain post-offset)
  wire [2:0] mode = {f_post, f_deref, f_pre};
  wire [`EAG_WORD_W-1:0] base = mode_base(mode, instr_addr, cur_ptr);
  wire [`EAG_WORD_W-1:0] zero_w = `EAG_ADDR_RST;
  wire [`EAG_WORD_W-1:0] post_add = f_post ? cur_post : zero_w;
  wire [`EAG_WORD_W-1:0] inter_addr;
  wire [`EAG_WORD_W-1:0] direct_ea;
  wire [`EAG_WORD_W-1:0] indir_ea;
  reg [`EAG_WORD_W-1:0] held_post;

  // Pre-offset joins before the fetch
  eag_adder #(.W(`EAG_WORD_W)) u_pre (
    .a(base),
    .b(disp),
    .c(zero_w),
    .sum(inter_addr)
  );
  // Direct modes need one sum, so ea_valid rises the cycle after start
  eag_adder #(.W(`EAG_WORD_W)) u_dir (
    .a(base),
    .b(disp),
    .c(post_add),
    .sum(direct_ea)
  );
  // Post-offset only after the pointer word arrives
  eag_adder #(.W(`EAG_WORD_W)) u_post (
    .a(mem_rdata),
    .b(held_post),
    .c(zero_w),
    .sum(indir_ea)
  );

  // ----------------------------------------
  // Control
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_FETCH = 1'b1;
  reg state;
  reg next_state;
  assign busy = (state == ST_FETCH);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start && f_deref && !own_format)
          next_state = ST_FETCH;
      ST_FETCH:
        if (mem_ack)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      state <= ST_IDLE;
      mem_rd <= 1'b0;
      mem_addr <= `EAG_ADDR_RST;
      ea_valid <= 1'b0;
      ea <= `EAG_ADDR_RST;
      ea_opcode <= {`EAG_OPC_W{1'b0}};
      ea_bypass <= 1'b0;
      held_post <= `EAG_ADDR_RST;
    end
    else
    begin
      state <= next_state;
      ea_valid <= 1'b0;
      case (state)
        ST_IDLE:
          if (start)
          begin
            ea_opcode <= opc;
            ea_bypass <= own_format;
            if (own_format)
            begin
              // Other formats pass through with no address work
              ea_valid <= 1'b1;
              ea <= `EAG_ADDR_RST;
            end
            else if (f_deref)
            begin
              mem_rd <= 1'b1;
              mem_addr <= inter_addr;
              held_post <= post_add;
            end
            else
            begin
              ea_valid <= 1'b1;
              ea <= direct_ea;
            end
          end
        ST_FETCH:
          if (mem_ack)
          begin
            mem_rd <= 1'b0;
            ea_valid <= 1'b1;
            ea <= indir_ea;
          end
        default:
          mem_rd <= 1'b0;
      endcase
    end
  end
endmodule // eag_effective_address
`default_nettype wire

// ---- rtl/eag_defines.vh ----
`ifndef EAG_DEFINES_VH
`define EAG_DEFINES_VH
// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define EAG_OPC_MSB 15
`define EAG_OPC_LSB 11
`define EAG_POST_BIT 10
`define EAG_DEREF_BIT 9
`define EAG_PRE_BIT 8
`define EAG_DISP_MSB 7
`define EAG_WORD_W 16
`define EAG_DISP_W 8
`define EAG_OPC_W 5
`define EAG_LEVEL_W 4
`define EAG_ADDR_RST 16'h0000
`endif

// ---- rtl/eag_adder.v ----
`timescale 1ns/1ps
`default_nettype none
module eag_adder #(
  parameter W = 16
) (
  input wire [W-1:0] a,
  input wire [W-1:0] b,
  input wire [W-1:0] c,
  output wire [W-1:0] sum
);
  // Carry out of the top bit is dropped, addresses wrap
  wire [W+1:0] full;
  assign full = {2'b00, a} + {2'b00, b} + {2'b00, c};
  assign sum = full[W-1:0];
endmodule // eag_adder
`default_nettype wire

// ---- verif/eag_memory.sv ----
`timescale 1ns/1ps
`default_nettype none
module eag_memory (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic [1:0] lat,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  // ----------------
  // Pointer store
  // ----------------
  int n = 0;
  initial mem_ack = 0;
  initial mem_rdata = 16'h0000;
  // Idle data flips every cycle so a stale word never looks valid
  always @(posedge clk)
  begin
    mem_ack <= mem_rd && !mem_ack && n >= lat;
    mem_rdata <= (mem_rd && !mem_ack && n >= lat) ? mem_addr ^ 16'hA5C3 : ~mem_rdata;
    n <= (mem_rd && !mem_ack && n < lat) ? n + 1 : 0;
  end
endmodule // eag_memory
`default_nettype wire

// ---- verif/eag_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module eag_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [15:0] instr_word,
  input wire logic [15:0] instr_addr,
  input wire logic busy,
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic ea_valid,
  input wire logic [15:0] ea,
  input wire logic [4:0] ea_opcode
);
  // ----------------
  // Checks
  // ----------------
  wire logic [15:0] sx = {{8{instr_word[7]}}, instr_word[7:0]};
  wire logic [15:0] rel_sum = instr_addr + sx;
  wire logic go = start && !busy;
  wire logic own = instr_word[15:12] == 4'hD || instr_word[15:11] == 5'h1C;
  logic post = 0;
  always @(posedge clk) if (go) post <= instr_word[10];
  logic [4:0] opc_q = 0;
  always @(posedge clk) if (go) opc_q <= instr_word[15:11];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  direct_one_a: assert property (go && !instr_word[9] |=> ea_valid) else $error("slow direct");
  deref_wait_a: assert property (go && instr_word[9] && !own |=> mem_rd && !ea_valid) else $error("no fetch");
  ack_done_a: assert property (mem_rd && mem_ack |=> ea_valid && !mem_rd) else $error("ack lost");
  rd_hold_a: assert property (mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr)) else $error("rd drop");
  rd_busy_a: assert property (mem_rd |-> busy) else $error("not busy");
  word_ea_a: assert property (mem_rd && mem_ack && !post |=> ea == $past(mem_rdata)) else $error("bad ptr");
  opc_out_a: assert property (go |=> ##[0:8] ea_valid ##0 ea_opcode == opc_q)
    else $error("bad opcode");
  rel_ea_a: assert property (go && instr_word[10:8] == 3'b000 && !own |=> ea == $past(rel_sum))
    else $error("bad rel");
  ind_addr_a: assert property (go && instr_word[10:8] == 3'b010 && !own |=> mem_addr == $past(rel_sum))
    else $error("bad ind");
endmodule // eag_checker
bind eag_effective_address eag_checker eag_checker_inst (.clk, .srst, .start, .instr_word,
  .instr_addr, .busy, .mem_rd, .mem_addr, .mem_ack, .mem_rdata, .ea_valid, .ea, .ea_opcode);
`default_nettype wire

// ---- verif/eag_effective_address_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module eag_effective_address_tb;
  logic clk = 0, srst = 1, start = 0, lvl_wr = 0, busy, mem_rd, mem_ack, ea_valid, ea_bypass;
  logic [15:0] instr_word = 0, instr_addr = 0, lp = 0, lx = 0, mem_addr, mem_rdata, ea;
  logic [3:0] lvl = 0, wl = 0;
  logic [4:0] ea_opcode;
  logic [1:0] lat = 0;
  logic [15:0] pt [16], px [16];
  int bad_count = 0, checked = 0;
  // ----------------
  // Harness
  // ----------------
  always #12.5 clk = ~clk;
  eag_effective_address eag_effective_address_inst (.clk, .srst, .start, .instr_word,
    .instr_addr, .active_level(lvl), .lvl_wr, .lvl_wr_level(wl), .lvl_wr_pointer(lp),
    .lvl_wr_post(lx), .busy, .mem_rd, .mem_addr, .mem_ack, .mem_rdata, .ea_valid, .ea,
    .ea_opcode, .ea_bypass);
  eag_memory eag_memory_inst (.clk, .mem_rd, .mem_addr, .lat, .mem_ack, .mem_rdata);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) bad_count++;
    if (got !== exp) $display("MISMATCH %0t %h %h", $time, got, exp);
  endtask
  task final_report;
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [15:0] eag_exp(input logic [15:0] w, a, p, x, input logic by);
    logic [15:0] m;
    m = (w[8] ? p : (w[10] && !w[9]) ? 16'h0000 : a) + {{8{w[7]}}, w[7:0]};
    if (w[9]) m = m ^ 16'hA5C3;
    return by ? 16'h0000 : m + (w[10] ? x : 16'h0000);
  endfunction
  // Level stays fixed while busy, so it only moves with start
  task op(input logic [15:0] w, input logic [15:0] a);
    logic by;
    int c;
    by = w[15:11] inside {5'h1A, 5'h1B, 5'h1C};
    @(negedge clk);
    instr_word = w;
    instr_addr = a;
    lvl = $urandom;
    start = 1;
    @(negedge clk);
    start = 0;
    c = 1;
    while (ea_valid !== 1'b1 && c < 50)
    begin
      @(negedge clk);
      c++;
    end
    chk(ea, eag_exp(w, a, pt[lvl], px[lvl], by));
    chk(c, (by || !w[9]) ? 1 : lat + 3);
    chk({ea_bypass, ea_opcode}, {by, w[15:11]});
  endtask
  initial
  begin
    void'($urandom(85906));
    repeat (20) @(negedge clk);
    srst = 0;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk);
      lvl_wr = 1;
      wl = i;
      lp = $urandom;
      lx = $urandom;
      pt[i] = lp;
      px[i] = lx;
    end
    @(negedge clk);
    lvl_wr = 0;
    for (int i = 0; i < 8; i++) op({5'h03, i[2:0], i[0] ? 8'h80 : 8'h7F}, 16'hFFC0);
    for (int i = 0; i < 300; i++)
    begin
      lat = $urandom;
      op($urandom, $urandom);
    end
    final_report;
  end
  initial
  begin
    #500000;
    bad_count++;
    final_report;
  end
endmodule // eag_effective_address_tb
`default_nettype wire
